//--- bench/psr_host.sv
`timescale 1ns/100ps
`default_nettype none
module psr_host
(
	input wire psr_pkg::psr_byte_t data_i,
	output logic par_o
);
	assign par_o = ~^data_i;
endmodule
`default_nettype wire

//--- bench/psr_props.sv
`timescale 1ns/100ps
`default_nettype none
module psr_props #(parameter logic SELF_START = 1'b0, parameter logic [5:0] PART_CODE = 6'h00,
	parameter logic [2:0] SILICON_REVISION = 3'h0)
(
	input wire logic clk_i, srst_i, wr_i, rd_i, parity_i, parity_err_o, seq_start_o, fault_pin_n_o,
	input wire psr_pkg::psr_addr_t addr_i,
	input wire psr_pkg::psr_byte_t wdata_i, rdata_o,
	input wire logic [7:0] rail_fault_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire good = ^{wdata_i, parity_i};
	property p_good; wr_i && good |=> !parity_err_o; endproperty
	a_good: assert property (p_good) else $error("good write refused");
	property p_err; parity_err_o |-> $past(wr_i && !good); endproperty
	a_err: assert property (p_err) else $error("stray parity error");
	property p_start; wr_i && good && addr_i == 7'h02 |=> seq_start_o == $past(wdata_i[6]); endproperty
	a_start: assert property (p_start) else $error("start not written");
	property p_hold; !$past(srst_i || wr_i && addr_i == 7'h02) |-> $stable(seq_start_o); endproperty
	a_hold: assert property (p_hold) else $error("start moved");
	property p_rst; $fell(srst_i) |-> seq_start_o == SELF_START && fault_pin_n_o; endproperty
	a_rst: assert property (p_rst) else $error("bad reset level");
	property p_clear; (rail_fault_i == 8'h00) [*3] |=> fault_pin_n_o; endproperty
	a_clear: assert property (p_clear) else $error("pin low without fault");
	property p_ident; rd_i && addr_i == 7'h00 |=> rdata_o[5:0] == PART_CODE; endproperty
	a_ident: assert property (p_ident) else $error("bad part code");
	property p_ctrl; rd_i && addr_i == 7'h02 |=> rdata_o[5:3] <= 3'h6 && rdata_o[2:0] == SILICON_REVISION; endproperty
	a_ctrl: assert property (p_ctrl) else $error("bad control read");
	c_err: cover property (parity_err_o);
	c_start: cover property (seq_start_o);
	c_pin: cover property (!fault_pin_n_o);
endmodule
bind psr_regs psr_props #(.SELF_START(SELF_START), .PART_CODE(PART_CODE),
	.SILICON_REVISION(SILICON_REVISION)) u_props (.*);
`default_nettype wire

//--- bench/psr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module psr_regs_bench;
	logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, bad = 0, tv = 0, pd = 0;
	psr_pkg::psr_addr_t ad = 7'h00;
	psr_pkg::psr_byte_t wd = 8'h00, ts = 8'h00, rf = 8'h00, rdat, nvm, nvx;
	wire hp, perr, start, burn, pin_n, rld, rst_cmd, start_ss;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	psr_host host (.data_i(wd), .par_o(hp));
	psr_regs #(.PART_CODE(6'h15), .SILICON_REVISION(3'h3)) dut (.clk_i(clk_i), .srst_i(srst_i), .wr_i(wr_i),
		.rd_i(rd_i), .addr_i(ad), .wdata_i(wd), .parity_i(hp ^ bad), .temp_sample_i(ts), .temp_valid_i(tv),
		.program_done_i(pd), .rail_fault_i(rf), .rdata_o(rdat), .parity_err_o(perr), .seq_start_o(start),
		.burn_o(burn), .reload_o(rld), .restart_o(rst_cmd), .nv_min_o(nvm), .nv_max_o(nvx), .nv_boost_o(),
		.nv_gate_hi_o(), .nv_gate_lo_o(), .fault_pin_n_o(pin_n));
	psr_regs #(.SELF_START(1'b1)) dut_self (.clk_i(clk_i), .srst_i(srst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(ad),
		.wdata_i(wd), .parity_i(hp ^ bad), .temp_sample_i(ts), .temp_valid_i(tv), .program_done_i(pd),
		.rail_fault_i(rf), .rdata_o(), .parity_err_o(), .seq_start_o(start_ss), .burn_o(), .reload_o(),
		.restart_o(), .nv_min_o(), .nv_max_o(), .nv_boost_o(), .nv_gate_hi_o(), .nv_gate_lo_o(), .fault_pin_n_o());
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 2000) begin bad_count++; give_verdict; end
	task give_verdict;
		if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input psr_pkg::psr_byte_t g, e);
		cmp_count++;
		if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
		bad_count += (g !== e);
	endtask
	task automatic wr(input psr_pkg::psr_addr_t a, input psr_pkg::psr_byte_t d, input logic b = 1'b0);
		@(negedge clk_i) {wr_i, ad, wd, bad} = {1'b1, a, d, b};
		@(negedge clk_i) wr_i = 0;
	endtask
	task automatic rd(input psr_pkg::psr_addr_t a, input psr_pkg::psr_byte_t e);
		@(negedge clk_i) {rd_i, ad} = {1'b1, a};
		@(negedge clk_i) rd_i = 0;
		chk(rdat, e);
	endtask
	task t_reset;
		rd(7'h03, 8'h00); rd(7'h01, 8'h00);
		rd(7'h02, 8'h03); rd(7'h00, 8'h15); rd(7'h40, 8'h00); chk(start, 8'h00);
		chk(start_ss, 8'h01);
	endtask
	task t_mask;
		for (int i = 0; i < 8; i++)
		begin
			rf = 8'h01 << i; repeat (4) @(negedge clk_i); chk(pin_n, 8'h00);
			wr(7'h03, 8'h01 << i); repeat (3) @(negedge clk_i); chk(pin_n, 8'h01);
			wr(7'h03, 8'h00);
		end
		rf = 8'h00; wr(7'h03, 8'ha5); rd(7'h03, 8'ha5);
	endtask
	task t_parity;
		wr(7'h21, 8'h3c, 1'b1); chk(perr, 8'h00); chk(nvm, 8'h3c);
		wr(7'h22, 8'h5c, 1'b1); chk(nvx, 8'h5c);
		wr(7'h02, 8'h80); wr(7'h21, 8'h77, 1'b1); chk(perr, 8'h01); chk(nvm, 8'h3c);
		wr(7'h21, 8'h77); chk(nvm, 8'h77); wr(7'h02, 8'h00);
	endtask
	task t_start;
		wr(7'h02, 8'h7f); chk(start, 8'h01); rd(7'h02, 8'h43);
		wr(7'h78, 8'h00); chk(burn, 8'h01); wr(7'h02, 8'h00); chk(start, 8'h00);
		wr(7'h79, 8'h00); chk(rld, 8'h01); wr(7'h7a, 8'h00); chk(rst_cmd, 8'h01);
	endtask
	task t_tally;
		repeat (7) begin @(negedge clk_i) pd = 1; @(negedge clk_i) pd = 0; end
		rd(7'h02, 8'h33);
		@(negedge clk_i) {tv, ts} = {1'b1, 8'h5a}; @(negedge clk_i) tv = 0;
		wr(7'h01, 8'h00); wr(7'h00, 8'hff); rd(7'h01, 8'h5a); rd(7'h00, 8'h15);
	endtask
	initial
	begin
		repeat (2) @(negedge clk_i); srst_i = 0;
		t_reset; t_mask; t_parity; t_start; t_tally;
		give_verdict;
	end
endmodule
`default_nettype wire

//--- rtl/psr_cfg.svh
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
`define PSR_OFS_IDENT 7'h00
`define PSR_OFS_TEMP 7'h01
`define PSR_OFS_CTRL 7'h02
`define PSR_OFS_MASK 7'h03
`define PSR_OFS_NV_MIN 7'h21
`define PSR_OFS_NV_MAX 7'h22
`define PSR_OFS_NV_BOOST 7'h23
`define PSR_OFS_NV_GHI 7'h24
`define PSR_OFS_NV_GLO 7'h25
`define PSR_OFS_BURN 7'h78
`define PSR_OFS_RELOAD 7'h79
`define PSR_OFS_RESTART 7'h7A
`define PSR_CTRL_PAR_BIT 7
`define PSR_CTRL_START_BIT 6
`define PSR_TALLY_MAX 3'h6
`define PSR_RST_BYTE 8'h00
`define PSR_RST_BIT 1'b0
`define PSR_PIN_IDLE 1'b1
`define PSR_TALLY_RST 3'h0
`define PSR_TALLY_STEP 3'h1
`define PSR_PROGRAM_CYCLE_TALLY 5
`define PSR_IDENT_PAD 2'b00
`endif

//--- rtl/psr_pkg.sv
package psr_pkg;
	typedef logic [7:0] psr_byte_t;
	typedef logic [6:0] psr_addr_t;
endpackage

//--- rtl/psr_regs.sv
// Overview of operation
// R1: Control bit 7 enables parity checking of every write; when clear, writes are never checked; it resets to 0.
// R2: Writing 1 to control bit 6 launches the selected power-up sequence; it resets to 0 in the standard variant.
// R3: In the self-starting variant control bit 6 resets to 1 so the sequence runs without a write.
// R4: Control bits 5:3 report how many memory programming operations happened, saturating at 6.
// R5: The temperature register at 0x01 is read-only, shows the digitised reference-pin voltage and is 0 after reset.
// R6: Mask bit 7 stops a high-voltage input or boost overvoltage from pulling the fault pin low; reset 0.
// R7: Mask bit 6 stops a positive analog rail undervoltage from pulling the fault pin low; reset 0.
// R8: Mask bits 5 and 4 stop negative analog rail overvoltage and undervoltage from pulling the fault pin low.
// R9: Mask bits 3 and 2 stop gate-high supply overvoltage and undervoltage from pulling the fault pin low.
// R10: Mask bit 1 stops a gate-low supply overvoltage from pulling the fault pin low; read/write, reset 0.
// R11: Mask bit 0 stops a gate-low supply undervoltage from pulling the fault pin low; read/write, reset 0.
// R12: The host adjusts parity of command writes through the payload byte and never changes the command byte.
// R13: The fault pin is low while any unmasked rail fault is present and released when none remains.
// R14: Writes to the identity, temperature, tally and revision fields are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "psr_cfg.svh"
module psr_regs
#(
	parameter logic SELF_START = 1'b0,
	parameter logic [5:0] PART_CODE = 6'h2A,     // Arbitrary value
	parameter logic [2:0] SILICON_REVISION = 3'h5 // Arbitrary value
)
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire psr_pkg::psr_addr_t addr_i,
	input wire psr_pkg::psr_byte_t wdata_i,
	input wire logic parity_i,
	input wire psr_pkg::psr_byte_t temp_sample_i,
	input wire logic temp_valid_i,
	input wire logic program_done_i,
	input wire logic [7:0] rail_fault_i,
	output psr_pkg::psr_byte_t rdata_o,
	output logic parity_err_o,
	output logic seq_start_o,
	output logic burn_o,
	output logic reload_o,
	output logic restart_o,
	output psr_pkg::psr_byte_t nv_min_o,
	output psr_pkg::psr_byte_t nv_max_o,
	output psr_pkg::psr_byte_t nv_boost_o,
	output psr_pkg::psr_byte_t nv_gate_hi_o,
	output psr_pkg::psr_byte_t nv_gate_lo_o,
	output logic fault_pin_n_o
);

	//////////////////////////////////////////////////////////////////////
	// Pin synchronisers for asynchronous fault comparators
	logic [7:0] flt_s1_q, flt_s2_q;
	always_ff @(posedge clk_i)
	begin
		flt_s1_q <= rail_fault_i;
		flt_s2_q <= flt_s1_q;
	end

	//////////////////////////////////////////////////////////////////////
	// Register state
	logic par_en_q, par_en_d, start_q, start_d, perr_q, perr_d;
	logic [2:0] tally_q, tally_d;
	psr_pkg::psr_byte_t temp_q, temp_d, mask_q, mask_d;
	psr_pkg::psr_byte_t nv_q [`PSR_PROGRAM_CYCLE_TALLY], nv_d [`PSR_PROGRAM_CYCLE_TALLY];
	psr_pkg::psr_byte_t rdata_q, rdata_d;
	logic burn_q, burn_d, reload_q, reload_d, restart_q, restart_d;
	logic fault_n_q, fault_n_d;
	logic wr_ok, wr_ctrl, wr_mask, wr_nv;

	// Tally and revision must sit exactly below the two writable control bits
	if ($bits(SILICON_REVISION) + $bits(tally_q) != `PSR_CTRL_START_BIT)
	begin : g_bad_layout
		$error("control byte layout does not fit");
	end

	//////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic logic is_nv(input psr_pkg::psr_addr_t a);
		is_nv = (a >= `PSR_OFS_NV_MIN) && (a <= `PSR_OFS_NV_GLO);
	endfunction

	function automatic logic [2:0] nv_index(input psr_pkg::psr_addr_t a);
		nv_index = 3'(a - `PSR_OFS_NV_MIN);
	endfunction

	always_comb
	begin
		// Odd parity over data byte plus parity bit
		wr_ok = wr_i && (!par_en_q || (^{wdata_i, parity_i})); // R1
		// Identity, temperature, tally and revision have no write path
		wr_ctrl = wr_ok && (addr_i == `PSR_OFS_CTRL); // R14
		wr_mask = wr_ok && (addr_i == `PSR_OFS_MASK);
		wr_nv = wr_ok && is_nv(addr_i);
	end

	//////////////////////////////////////////////////////////////////////
	// Control bits and parity error
	always_comb
	begin
		par_en_d = par_en_q;
		start_d = start_q;
		if (wr_ctrl)
		begin
			par_en_d = wdata_i[`PSR_CTRL_PAR_BIT]; // R1
			start_d = wdata_i[`PSR_CTRL_START_BIT]; // R2
		end
		// A refused write leaves no trace but this one-cycle pulse
		perr_d = wr_i && !wr_ok; // R1
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			par_en_q <= `PSR_RST_BIT; // R1
			start_q <= SELF_START; // R2 R3
			perr_q <= `PSR_RST_BIT;
		end
		else
		begin
			par_en_q <= par_en_d;
			start_q <= start_d;
			perr_q <= perr_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Programming tally and temperature reading
	always_comb
	begin
		tally_d = tally_q;
		// Saturate rather than wrap so a worn memory never reads as fresh
		if (program_done_i && tally_q != `PSR_TALLY_MAX)
			tally_d = 3'(tally_q + `PSR_TALLY_STEP); // R4
		temp_d = temp_valid_i ? temp_sample_i : temp_q; // R5
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			tally_q <= `PSR_TALLY_RST;
			temp_q <= `PSR_RST_BYTE; // R5
		end
		else
		begin
			tally_q <= tally_d;
			temp_q <= temp_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Fault mask and fault pin
	always_comb
	begin
		mask_d = wr_mask ? wdata_i : mask_q; // R6 R7 R8 R9 R10 R11
		// Any unmasked fault drives the pin low
		fault_n_d = ~|(flt_s2_q & ~mask_q); // R13 R6 R7 R8 R9 R10 R11
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mask_q <= `PSR_RST_BYTE;
			fault_n_q <= `PSR_PIN_IDLE;
		end
		else
		begin
			mask_q <= mask_d;
			fault_n_q <= fault_n_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Nonvolatile shadows
	always_comb
	begin
		nv_d = nv_q;
		if (wr_nv)
			nv_d[nv_index(addr_i)] = wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < `PSR_PROGRAM_CYCLE_TALLY; i++)
				nv_q[i] <= `PSR_RST_BYTE;
		end
		else
			nv_q <= nv_d;
	end

	//////////////////////////////////////////////////////////////////////
	// Command strobes
	always_comb
	begin
		// Any payload fires the command, so the host is free to trim parity with it
		burn_d = wr_ok && (addr_i == `PSR_OFS_BURN);
		reload_d = wr_ok && (addr_i == `PSR_OFS_RELOAD);
		restart_d = wr_ok && (addr_i == `PSR_OFS_RESTART);
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			burn_q <= `PSR_RST_BIT;
			reload_q <= `PSR_RST_BIT;
			restart_q <= `PSR_RST_BIT;
		end
		else
		begin
			burn_q <= burn_d;
			reload_q <= reload_d;
			restart_q <= restart_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Read data
	always_comb
	begin
		rdata_d = rdata_q;
		if (rd_i)
		begin
			if (is_nv(addr_i))
				rdata_d = nv_q[nv_index(addr_i)];
			else
			begin
				unique case (addr_i)
					`PSR_OFS_IDENT: rdata_d = {`PSR_IDENT_PAD, PART_CODE};
					`PSR_OFS_TEMP: rdata_d = temp_q;
					`PSR_OFS_CTRL: rdata_d = {par_en_q, start_q, tally_q, SILICON_REVISION};
					`PSR_OFS_MASK: rdata_d = mask_q;
					default: rdata_d = `PSR_RST_BYTE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_q <= `PSR_RST_BYTE;
		else
			rdata_q <= rdata_d;
	end

	assign rdata_o = rdata_q;
	assign parity_err_o = perr_q;
	assign seq_start_o = start_q; // R2
	assign burn_o = burn_q;
	assign reload_o = reload_q;
	assign restart_o = restart_q;
	assign nv_min_o = nv_q[0];
	assign nv_max_o = nv_q[1];
	assign nv_boost_o = nv_q[2];
	assign nv_gate_hi_o = nv_q[3];
	assign nv_gate_lo_o = nv_q[4];
	assign fault_pin_n_o = fault_n_q;

endmodule
`default_nettype wire
